// *** design/adcsq_defs.vh ***
// Notes on behaviour
// RULE_01: Control write aborts sequence; only a start register write starts one
// RULE_02: Length codes 1-7 literal; zero or top bit gives 8
// RULE_03: Reset length is four conversions
// RULE_04: Non-FIFO: Nth result into Nth slot
// RULE_05: FIFO: slot counter persists across sequences
// RULE_06: FIFO scan wraps slot counter to first
// RULE_07: Slot counter readable in status field
// RULE_08: Abort or control-write start clears slot counter
// RULE_09: Start register sequence lands in first slot
// RULE_10: One conversion-done flag per result slot
// RULE_11: Software uses FIFO only with scan/trigger
// RULE_12: Freeze 00 continue, 11 halt immediately
// RULE_13: Freeze 10 finishes conversion, then halts
// RULE_14: Fast clear: result access clears its flag
// RULE_15: Reserved freeze code 01 behaves as 00
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH

// Register indices; byte address is four times the index
`define ADCSQ_IDX_AUX 6'h02
`define ADCSQ_IDX_CTRL 6'h03
`define ADCSQ_IDX_START 6'h05
`define ADCSQ_IDX_STAT0 6'h06
`define ADCSQ_IDX_FLAGS 6'h07
`define ADCSQ_IDX_IRQ_ST 6'h08
`define ADCSQ_IDX_IRQ_MASK 6'h09
`define ADCSQ_IDX_RES_BASE 6'h10
`define ADCSQ_IDX_RES_MSB 3

// Control register fields
`define ADCSQ_CTRL_RESET 7'h20
`define ADCSQ_CTRL_LEN_MSB 6
`define ADCSQ_CTRL_LEN_LSB 3
`define ADCSQ_CTRL_FIFO 2
`define ADCSQ_CTRL_FRZ_MSB 1

// Auxiliary and start register fields
`define ADCSQ_AUX_FFC 6
`define ADCSQ_START_SCAN 0

// Freeze codes
`define ADCSQ_FRZ_CONT 2'h0
`define ADCSQ_FRZ_RSVD 2'h1
`define ADCSQ_FRZ_FINISH 2'h2
`define ADCSQ_FRZ_NOW 2'h3

// Interrupt status bits
`define ADCSQ_IRQ_SEQ 0
`define ADCSQ_IRQ_CONV 1
`define ADCSQ_IRQ_W 2

// Result storage
`define ADCSQ_SLOTS 8
`define ADCSQ_SLOT_W 3
`define ADCSQ_RES_W 10
`define ADCSQ_LEN_MAX 4'h8

`endif

// *** design/adcsq_result_mem.v ***
`timescale 1ns/1ns
module adcsq_result_mem
(
  input wire sys_clk,
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [9:0] wr_data,
  input wire [2:0] rd_addr,
  output reg [9:0] rd_data
);

reg [9:0] mem [0:7];

// No reset: contents are only valid once the matching flag is set
always @(posedge sys_clk)
begin
  if (wr_en)
  begin
    mem[wr_addr] <= wr_data;
  end
  rd_data <= mem[rd_addr];
end

endmodule

// *** design/adcsq_top.v ***
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`include "adcsq_defs.vh"
module adcsq_top
(
  input wire sys_clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire dbg_freeze,
  input wire conv_busy,
  input wire conv_done,
  input wire [9:0] conv_result,
  output wire conv_run,
  output reg seq_abort,
  output wire [2:0] result_slot_counter,
  output wire irq
);

localparam ST_IDLE = 2'b01;
localparam ST_RUN = 2'b10;

// Sequence length from the four length bits
function [3:0] adcsq_seq_len;
  input [3:0] code;
  begin
    if (code[3] || code == 4'h0)
    begin
      adcsq_seq_len = `ADCSQ_LEN_MAX;
    end
    else
    begin
      adcsq_seq_len = {1'b0, code[2:0]};
    end
  end
endfunction

// Index match, shared by the write strobes and read arming
function adcsq_sel;
  input [5:0] index;
  input [5:0] target;
  begin
    adcsq_sel = (index == target);
  end
endfunction

reg [6:0] ctrl_reg;
reg fast_clear_reg;
reg scan_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [2:0] slot_reg;
reg [2:0] slot_next;
reg [3:0] seq_cnt_reg;
reg [3:0] seq_cnt_next;
reg [7:0] done_flag_reg;
reg [7:0] done_flag_next;
reg [7:0] armed_reg;
reg [7:0] armed_next;
reg seq_complete_reg;
reg [1:0] irq_st_reg;
reg [1:0] irq_st_next;
reg [1:0] irq_mask_reg;
reg busy_reg;
reg ack_reg;
reg seq_end;
reg halt;

wire [9:0] mem_rd_data;
wire [5:0] idx;
wire access;
wire wr_acc;
wire rd_acc;
wire ctrl_write;
wire start_write;
wire res_hit;
wire [2:0] res_slot;
wire [3:0] seq_len;
wire [1:0] frz_code;
wire fifo_mode;
wire take_result;
wire aux_write;
wire len_write;
wire irq_st_write;
wire mask_write;
wire flags_read;

assign idx = wb_adr_i[7:2];
// Request is registered one cycle, taken the next, and acked the cycle after
assign access = wb_cyc_i & wb_stb_i & busy_reg & ~ack_reg;
assign wr_acc = access & wb_we_i & wb_sel_i[0];
assign rd_acc = access & ~wb_we_i;
// Result slots fill one aligned block of eight indices
assign res_hit = ((idx & 6'h38) == `ADCSQ_IDX_RES_BASE);
assign res_slot = idx[2:0];
assign aux_write = wr_acc & adcsq_sel(idx, `ADCSQ_IDX_AUX);
assign len_write = wr_acc & adcsq_sel(idx, `ADCSQ_IDX_CTRL);
assign start_write = wr_acc & adcsq_sel(idx, `ADCSQ_IDX_START);
assign irq_st_write = wr_acc & adcsq_sel(idx, `ADCSQ_IDX_IRQ_ST);
assign mask_write = wr_acc & adcsq_sel(idx, `ADCSQ_IDX_IRQ_MASK);
assign flags_read = rd_acc & adcsq_sel(idx, `ADCSQ_IDX_FLAGS);
// Every control write aborts; only the start register restarts
assign ctrl_write = aux_write | len_write | start_write; // RULE_01
assign wb_ack_o = ack_reg;
assign seq_len = adcsq_seq_len(ctrl_reg[`ADCSQ_CTRL_LEN_MSB:
                                        `ADCSQ_CTRL_LEN_LSB]); // RULE_02
assign frz_code = ctrl_reg[`ADCSQ_CTRL_FRZ_MSB:0];
assign fifo_mode = ctrl_reg[`ADCSQ_CTRL_FIFO];
assign result_slot_counter = slot_reg; // RULE_07
// A result racing a control write is dropped with the aborted sequence
assign take_result = conv_done & (state_reg == ST_RUN) & ~ctrl_write;
assign conv_run = (state_reg == ST_RUN) & ~halt;
assign irq = |(irq_st_reg & irq_mask_reg);

// Breakpoint response
always @*
begin
  case (frz_code)
    `ADCSQ_FRZ_NOW: halt = dbg_freeze; // RULE_12
    // Finish the running conversion first
    `ADCSQ_FRZ_FINISH: halt = dbg_freeze & ~conv_busy; // RULE_13
    `ADCSQ_FRZ_RSVD: halt = 1'b0; // RULE_15
    default: halt = 1'b0; // RULE_12
  endcase
end

// Sequence and slot counter
always @*
begin
  state_next = state_reg;
  slot_next = slot_reg;
  seq_cnt_next = seq_cnt_reg;
  seq_end = 1'b0;
  case (state_reg)
    ST_IDLE:
    begin
      state_next = ST_IDLE;
    end
    ST_RUN:
    begin
      if (take_result)
      begin
        if (seq_cnt_reg + 4'h1 >= seq_len)
        begin
          seq_end = 1'b1;
          seq_cnt_next = 4'h0;
          if (!scan_reg)
          begin
            state_next = ST_IDLE;
          end
        end
        else
        begin
          seq_cnt_next = seq_cnt_reg + 4'h1;
        end
        if (fifo_mode)
        begin
          // Natural 3-bit wrap past the last slot
          slot_next = slot_reg + 3'h1; // RULE_05 RULE_06
        end
        else if (seq_end)
        begin
          slot_next = 3'h0; // RULE_04
        end
        else
        begin
          slot_next = seq_cnt_next[2:0]; // RULE_04
        end
      end
    end
    default:
    begin
      state_next = ST_IDLE;
    end
  endcase
  if (ctrl_write)
  begin
    seq_cnt_next = 4'h0;
    slot_next = 3'h0; // RULE_08 RULE_09
    state_next = start_write ? ST_RUN : ST_IDLE; // RULE_01
  end
end

// Conversion-done flags
always @*
begin
  done_flag_next = done_flag_reg;
  armed_next = armed_reg;
  if (flags_read && !fast_clear_reg)
  begin
    armed_next = done_flag_reg;
  end
  if (rd_acc && res_hit)
  begin
    if (fast_clear_reg)
    begin
      done_flag_next[res_slot] = 1'b0; // RULE_14
    end
    else if (armed_reg[res_slot])
    begin
      done_flag_next[res_slot] = 1'b0; // RULE_14
      armed_next[res_slot] = 1'b0;
    end
  end
  // Set wins over a clear in the same cycle
  if (take_result)
  begin
    done_flag_next[slot_reg] = 1'b1; // RULE_10
    armed_next[slot_reg] = 1'b0;
  end
end

// Interrupt status, write one to clear, set wins
always @*
begin
  irq_st_next = irq_st_reg;
  if (irq_st_write)
  begin
    irq_st_next = irq_st_reg & ~wb_dat_i[`ADCSQ_IRQ_W-1:0];
  end
  if (seq_end)
  begin
    irq_st_next[`ADCSQ_IRQ_SEQ] = 1'b1;
  end
  if (take_result)
  begin
    irq_st_next[`ADCSQ_IRQ_CONV] = 1'b1;
  end
end

always @(posedge sys_clk or negedge rstn)
begin
  if (!rstn)
  begin
    ctrl_reg <= `ADCSQ_CTRL_RESET; // RULE_03
    fast_clear_reg <= 1'b0;
    scan_reg <= 1'b0;
    state_reg <= ST_IDLE;
    slot_reg <= 3'h0;
    seq_cnt_reg <= 4'h0;
    done_flag_reg <= 8'h00;
    armed_reg <= 8'h00;
    seq_complete_reg <= 1'b0;
    irq_st_reg <= 2'h0;
    irq_mask_reg <= 2'h0;
    seq_abort <= 1'b0;
    busy_reg <= 1'b0;
    ack_reg <= 1'b0;
  end
  else
  begin
    state_reg <= state_next;
    slot_reg <= slot_next;
    seq_cnt_reg <= seq_cnt_next;
    done_flag_reg <= done_flag_next;
    armed_reg <= armed_next;
    irq_st_reg <= irq_st_next;
    // One-cycle abort toward the converter on any control write
    seq_abort <= ctrl_write; // RULE_01 RULE_08
    if (ctrl_write)
    begin
      seq_complete_reg <= 1'b0;
    end
    else if (seq_end)
    begin
      seq_complete_reg <= 1'b1;
    end
    if (len_write)
    begin
      ctrl_reg <= wb_dat_i[6:0];
    end
    if (aux_write)
    begin
      fast_clear_reg <= wb_dat_i[`ADCSQ_AUX_FFC];
    end
    if (start_write)
    begin
      scan_reg <= wb_dat_i[`ADCSQ_START_SCAN];
    end
    if (mask_write)
    begin
      irq_mask_reg <= wb_dat_i[`ADCSQ_IRQ_W-1:0];
    end
    // Ack cycle frees busy, so a held request is not taken twice
    if (ack_reg)
    begin
      busy_reg <= 1'b0;
    end
    else if (wb_cyc_i && wb_stb_i)
    begin
      busy_reg <= 1'b1;
    end
    ack_reg <= access;
  end
end

// Read data register; unmapped indices read zero
always @(posedge sys_clk or negedge rstn)
begin
  if (!rstn)
  begin
    wb_dat_o <= 32'h00000000;
  end
  else if (rd_acc)
  begin
    if (res_hit)
    begin
      wb_dat_o <= {22'h000000, mem_rd_data};
    end
    else
    begin
      case (idx)
        `ADCSQ_IDX_CTRL: wb_dat_o <= {25'h0000000, ctrl_reg};
        `ADCSQ_IDX_AUX:
          wb_dat_o <= {25'h0000000, fast_clear_reg, 6'h00};
        `ADCSQ_IDX_START: wb_dat_o <= {31'h00000000, scan_reg};
        `ADCSQ_IDX_STAT0:
          wb_dat_o <= {24'h000000, seq_complete_reg,
                       state_reg == ST_RUN, 3'h0, slot_reg}; // RULE_07
        `ADCSQ_IDX_FLAGS: wb_dat_o <= {24'h000000, done_flag_reg};
        `ADCSQ_IDX_IRQ_ST: wb_dat_o <= {30'h00000000, irq_st_reg};
        `ADCSQ_IDX_IRQ_MASK: wb_dat_o <= {30'h00000000, irq_mask_reg};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
end

adcsq_result_mem u_mem
(
  .sys_clk(sys_clk),
  .wr_en(take_result),
  .wr_addr(slot_reg),
  .wr_data(conv_result),
  .rd_addr(res_slot),
  .rd_data(mem_rd_data)
);

endmodule

// *** verif/adcsq_assertions.sv ***
`timescale 1ns/1ns
module adcsq_chk
(
  input wire sys_clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire dbg_freeze,
  input wire conv_busy,
  input wire conv_done,
  input wire conv_run,
  input wire seq_abort,
  input wire [2:0] result_slot_counter
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire [5:0] idx = wb_adr_i[7:2];
  wire wr = wb_ack_o & wb_we_i & wb_sel_i[0] & wb_cyc_i & wb_stb_i;
  wire [2:0] slot = result_slot_counter;
  wire take = conv_run & conv_done & !wb_cyc_i;
  // Shadow lags the design by one cycle, so ack cycles are excluded
  reg [6:0] ctl_reg;
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      ctl_reg <= 7'h20;
    else if (wr && idx == 6'h03)
      ctl_reg <= wb_dat_i[6:0];
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_ack;
    !wb_ack_o ##1 wb_ack_o;
  endsequence
  AST_ACK_LAT: assert property (s_req |=> s_ack)
    else $error("ack not two cycles after request");
  AST_ABORT: assert property (wr && idx == 6'h03 |-> seq_abort)
    else $error("control write gave no abort");
  AST_ABORT_PULSE: assert property (seq_abort |=> !seq_abort)
    else $error("abort longer than one cycle");
  AST_NO_START: assert property (wr && idx == 6'h03 |-> !conv_run [*2])
    else $error("control write started a sequence");
  AST_SLOT_CLR: assert property (wr && (idx == 6'h02 || idx == 6'h03 ||
    idx == 6'h05) |-> slot == 3'h0)
    else $error("slot counter not cleared by write");
  AST_FRZ_NOW: assert property (ctl_reg[1:0] == 2'h3 && dbg_freeze &&
    !wb_ack_o |-> !conv_run)
    else $error("immediate freeze did not halt");
  AST_FRZ_FIN: assert property (ctl_reg[1:0] == 2'h2 && dbg_freeze &&
    !conv_busy && !wb_ack_o |-> !conv_run)
    else $error("finish freeze did not halt when idle");
  AST_FIFO_STEP: assert property (ctl_reg[2] && take |=>
    slot == $past(slot) + 3'h1)
    else $error("fifo slot did not step");
  AST_NF_STEP: assert property (!ctl_reg[2] && take |=>
    slot == $past(slot) + 3'h1 || slot == 3'h0)
    else $error("slot did not follow sequence");
endmodule
bind adcsq_top adcsq_chk u_chk (.*);

// *** verif/test_adcsq_top.sv ***
`timescale 1ns/1ns
module test_adcsq_top;
  reg sys_clk = 0;
  reg rstn = 0;
  reg wb_cyc_i = 0;
  reg wb_stb_i = 0;
  reg wb_we_i = 0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0;
  reg dbg_freeze = 0;
  reg conv_busy = 0;
  reg conv_done = 0;
  reg [9:0] conv_result = 10'h000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire conv_run;
  wire seq_abort;
  wire irq;
  wire [2:0] result_slot_counter;
  integer n_fail = 0;
  integer n_checks = 0;
  integer c;
  integer n;
  integer k;
  reg [31:0] q;
  adcsq_top u_dut (.*);
  always #4 sys_clk = ~sys_clk;
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
        n_fail = n_fail + 1;
        $display("ERROR %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task tick;
    @(posedge sys_clk);
  endtask
  task wb(input w, input [5:0] i, input [31:0] d);
    integer t;
    begin
      tick;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'h0};
      wb_dat_i <= d;
      t = 0;
      tick;
      while (wb_ack_o !== 1'b1 && t < 16)
      begin
        tick;
        t = t + 1;
      end
      if (wb_ack_o !== 1'b1)
      begin
        n_fail = n_fail + 1;
        end_of_test;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task rd(input [5:0] i, input [31:0] e);
    begin
      wb(1'b0, i, 32'h0);
      chk(q, e);
    end
  endtask
  task dn(input [9:0] r);
    begin
      tick;
      conv_done <= 1'b1;
      conv_result <= r;
      tick;
      conv_done <= 1'b0;
    end
  endtask
  task t_irq;
    begin
      rd(6'h03, 32'h20);
      rd(6'h3F, 32'h0);
      wb(1'b1, 6'h02, 32'h40);
      wb(1'b1, 6'h03, 32'h08);
      wb(1'b1, 6'h05, 32'h0);
      dn(10'h155);
      tick;
      chk(irq, 0);
      wb(1'b1, 6'h09, 32'h1);
      tick;
      chk(irq, 1);
      rd(6'h07, 32'h1);
      rd(6'h10, 32'h155);
      rd(6'h07, 32'h0);
      wb(1'b1, 6'h08, 32'h3);
      tick;
      chk(irq, 0);
      wb(1'b1, 6'h02, 32'h0);
      wb(1'b1, 6'h05, 32'h0);
      dn(10'h0AB);
      rd(6'h10, 32'hAB);
      rd(6'h07, 32'h1);
      rd(6'h10, 32'hAB);
      rd(6'h07, 32'h0);
      $display("irq and flags done");
    end
  endtask
  task t_len;
    for (c = 0; c < 16; c = c + 1)
    begin
      n = (c == 0 || c > 7) ? 8 : c;
      wb(1'b1, 6'h03, c << 3);
      wb(1'b1, 6'h05, 32'h0);
      for (k = 0; k < n - 1; k = k + 1)
        dn(c * 16 + k);
      tick;
      chk(conv_run, 1);
      dn(c * 16 + n - 1);
      tick;
      chk(conv_run, 0);
      chk(result_slot_counter, 0);
      rd(6'h10 + n - 1, c * 16 + n - 1);
    end
    $display("length done");
  endtask
  task t_fifo;
    begin
      wb(1'b1, 6'h03, 32'h1C);
      wb(1'b1, 6'h05, 32'h1);
      for (k = 0; k < 10; k = k + 1)
        dn(k);
      tick;
      chk(result_slot_counter, 2);
      wb(1'b0, 6'h06, 32'h0);
      chk(q[2:0], 2);
      rd(6'h11, 32'h9);
      wb(1'b1, 6'h03, 32'h1C);
      chk(result_slot_counter, 0);
      wb(1'b1, 6'h05, 32'h1);
      dn(10'h001);
      dn(10'h002);
      tick;
      chk(result_slot_counter, 2);
      wb(1'b1, 6'h05, 32'h0);
      chk(result_slot_counter, 0);
      dn(10'h2AA);
      rd(6'h10, 32'h2AA);
      $display("fifo done");
    end
  endtask
  task t_frz;
    for (c = 0; c < 4; c = c + 1)
    begin
      wb(1'b1, 6'h03, 32'h20 | c);
      wb(1'b1, 6'h05, 32'h1);
      dbg_freeze <= 1'b1;
      conv_busy <= 1'b1;
      tick;
      tick;
      chk(conv_run, c != 3);
      conv_busy <= 1'b0;
      tick;
      tick;
      chk(conv_run, c < 2);
      dbg_freeze <= 1'b0;
      tick;
      chk(conv_run, 1);
    end
    $display("freeze done");
  endtask
  initial
  begin
    repeat (4) tick;
    rstn <= 1'b1;
    t_irq;
    t_len;
    t_fifo;
    t_frz;
    end_of_test;
  end
endmodule
